/* design/sup_map.svh */
`ifndef SUP_MAP_SVH
`define SUP_MAP_SVH

// ==========================================================
// Register offsets (byte addresses)
`define SUP_OFF_CTRL     12'h000
`define SUP_OFF_DELIM    12'h004
`define SUP_OFF_PKTLEN   12'h008
`define SUP_OFF_GAP      12'h00c
`define SUP_OFF_LPORT    12'h010
`define SUP_OFF_STATUS   12'h014
`define SUP_OFF_FLUSHES  12'h018
`define SUP_OFF_DEST0    12'h020
`define SUP_DEST_STRIDE  12'h010
`define SUP_DOFF_FIRST   12'h000
`define SUP_DOFF_LAST    12'h004
`define SUP_DOFF_PORT    12'h008

// ==========================================================
// Field positions
`define SUP_CTRL_D1_EN   0
`define SUP_CTRL_D2_EN   1
`define SUP_CTRL_PROC_LO 2
`define SUP_CTRL_PROC_HI 3
`define SUP_PORT_EN      16
`define SUP_STAT_BUSY    16

// ==========================================================
// Reset values and sizes
`define SUP_RST_DELIM    8'h00
`define SUP_RST_PKTLEN   11'h000
`define SUP_RST_GAP      16'h0000
`define SUP_DEF_PORT     16'h0fa1
`define SUP_BUF_BYTES    1024
`define SUP_RANGE_MAX    64
`define SUP_NUM_RANGES   4
`define SUP_BCAST_OCTET  8'hff

// ==========================================================
// Timing
`define SUP_CLK_PERIOD_NS 25
`define SUP_MS_NS         1000000
`define SUP_MS_CYCLES     (`SUP_MS_NS / `SUP_CLK_PERIOD_NS)

`endif

/* design/sup_pkg.sv */
`default_nettype none
package sup_pkg;

  // Delimiter handling options, in register field order
  typedef enum logic [1:0] {
    PROC_NONE,
    PROC_PLUS1,
    PROC_PLUS2,
    PROC_STRIP
  } sup_proc_t;

  // Sender states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PICK,
    ST_DATA,
    ST_NEXT
  } sup_state_t;

  // One destination range
  typedef struct packed {
    logic        en;
    logic [15:0] port;
    logic [31:0] last;
    logic [31:0] first;
  } sup_dest_t;

  // Datagram header travelling beside the byte stream
  typedef struct packed {
    logic [31:0] dst_ip;
    logic [15:0] dst_port;
    logic [15:0] src_port;
    logic [10:0] len;
  } sup_txhdr_t;

endpackage
`default_nettype wire

/* design/sup_packer.sv */
// What this block does
// R01 - Length zero: no length threshold
// R02 - Send when count reaches packet length
// R03 - Delimiter one byte flushes buffer
// R04 - Both enabled: need both characters
// R05 - Delimiters only active when length zero
// R06 - Software: second delimiter only with first
// R07 - Delimiters on: still send over 1 KB
// R08 - Handling option needs first delimiter enabled
// R09 - Default option: send including delimiter
// R10 - Plus options: wait one/two more bytes
// R11 - Strip option: drop delimiter characters
// R12 - Gap setting zero disables timer
// R13 - Send when idle exceeds gap milliseconds
// R14 - Full 1 KB buffer always sends
// R15 - Software: gap longer than character time
// R16 - Sender: keep gaps short, total bounded
// R17 - Four ranges, one needed to send
// R18 - Ranges up to 64 addresses each
// R19 - Last octet 255 means broadcast
// R20 - Listen and destination port default 4001
// R21 - Reset defaults: delimiters off, zero settings
// R22 - Gap timer: ms ticks, restart, clear
// R23 - Simultaneous conditions give one flush
`timescale 1ns/1ps
`default_nettype none
`include "sup_map.svh"

module sup_packer #(
  parameter int BUF_BYTES  = `SUP_BUF_BYTES,
  parameter int NUM_RANGES = `SUP_NUM_RANGES,
  parameter int MS_CYCLES  = `SUP_MS_CYCLES
) (
  // Clock and reset
  input  wire logic               SYS_CLK,
  input  wire logic               SYS_RST,
  // AHB-Lite slave
  input  wire logic               HSEL,
  input  wire logic [11:0]        HADDR,
  input  wire logic [1:0]         HTRANS,
  input  wire logic               HWRITE,
  input  wire logic [2:0]         HSIZE,
  input  wire logic [31:0]        HWDATA,
  input  wire logic               HREADY,
  output logic                    HREADYOUT,
  output logic                    HRESP,
  output logic [31:0]             HRDATA,
  // Serial byte input
  input  wire logic               RX_VALID,
  input  wire logic [7:0]         RX_DATA,
  output logic                    RX_READY,
  // Datagram output
  output logic                    TX_VALID,
  output logic [7:0]              TX_DATA,
  output logic                    TX_LAST,
  output sup_pkg::sup_txhdr_t     TX_HDR,
  input  wire logic               TX_READY
);

  localparam int FW = 11;

  // ==========================================================
  // Parameter checks
  if (BUF_BYTES < 2 || BUF_BYTES > `SUP_BUF_BYTES) begin : g_chk_buf
    $error("BUF_BYTES must lie in 2..1024");
  end
  if (NUM_RANGES < 1 || NUM_RANGES > `SUP_NUM_RANGES) begin : g_chk_rng
    $error("NUM_RANGES must lie in 1..4");
  end
  if (MS_CYCLES < 1) begin : g_chk_ms
    $error("MS_CYCLES must be at least 1");
  end

  // ==========================================================
  // Declarations
  logic [7:0]          mem [BUF_BYTES];
  logic                d1_en_q;
  logic                d2_en_q;
  sup_pkg::sup_proc_t  proc_q;
  logic [7:0]          d1_q;
  logic [7:0]          d2_q;
  logic [FW-1:0]       pktlen_q;
  logic [15:0]         gap_q;
  logic [15:0]         lport_q;
  sup_pkg::sup_dest_t  dest_q [NUM_RANGES];
  logic [31:0]         flushes_q;
  logic                wr_pend_q;
  logic [11:0]         wr_addr_q;
  logic [FW-1:0]       fill_q;
  logic                prev_d1_q;
  logic [1:0]          post_q;
  logic [16:0]         gap_cnt_q;
  logic [31:0]         ms_div_q;
  logic                ms_tick_q;
  sup_pkg::sup_state_t state_q;
  logic [FW-1:0]       send_len_q;
  logic [FW-1:0]       rd_q;
  logic [2:0]          range_q;
  logic [5:0]          off_q;

  // ==========================================================
  // Register decode
  function automatic logic dest_hit(input logic [11:0] a, input int i,
                                    input logic [11:0] field);
    dest_hit = a == 12'(`SUP_OFF_DEST0 + 12'(i) * `SUP_DEST_STRIDE + field);
  endfunction

  function automatic logic [31:0] rd_mux(input logic [11:0] a);
    rd_mux = 32'h0000_0000;
    if (a == `SUP_OFF_CTRL) begin
      rd_mux = {28'h000_0000, proc_q, d2_en_q, d1_en_q};
    end else if (a == `SUP_OFF_DELIM) begin
      rd_mux = {16'h0000, d2_q, d1_q};
    end else if (a == `SUP_OFF_PKTLEN) begin
      rd_mux = {21'h00_0000, pktlen_q};
    end else if (a == `SUP_OFF_GAP) begin
      rd_mux = {16'h0000, gap_q};
    end else if (a == `SUP_OFF_LPORT) begin
      rd_mux = {16'h0000, lport_q};
    end else if (a == `SUP_OFF_STATUS) begin
      rd_mux = {15'h0000, state_q != sup_pkg::ST_IDLE, 5'h00, fill_q};
    end else if (a == `SUP_OFF_FLUSHES) begin
      rd_mux = flushes_q;
    end else begin
      for (int i = 0; i < NUM_RANGES; i++) begin
        if (dest_hit(a, i, `SUP_DOFF_FIRST)) begin
          rd_mux = dest_q[i].first;
        end else if (dest_hit(a, i, `SUP_DOFF_LAST)) begin
          rd_mux = dest_q[i].last;
        end else if (dest_hit(a, i, `SUP_DOFF_PORT)) begin
          rd_mux = {15'h0000, dest_q[i].en, dest_q[i].port};
        end
      end
    end
  endfunction

  // ==========================================================
  // AHB-Lite slave: zero wait states, always OKAY
  logic addr_ok;
  assign addr_ok = HSEL && HREADY && HTRANS[1];

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
      HRDATA    <= 32'h0000_0000;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
      wr_pend_q <= addr_ok && HWRITE;
      if (addr_ok) begin
        wr_addr_q <= {HADDR[11:2], 2'b00};
      end
      if (addr_ok && !HWRITE) begin
        HRDATA <= rd_mux({HADDR[11:2], 2'b00});
      end
    end
  end

  // Writable settings
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      d1_en_q  <= 1'b0;                          // R21
      d2_en_q  <= 1'b0;
      proc_q   <= sup_pkg::PROC_NONE;
      d1_q     <= `SUP_RST_DELIM;
      d2_q     <= `SUP_RST_DELIM;
      pktlen_q <= `SUP_RST_PKTLEN;
      gap_q    <= `SUP_RST_GAP;
      lport_q  <= `SUP_DEF_PORT;                 // R20
      for (int i = 0; i < NUM_RANGES; i++) begin
        dest_q[i] <= '{en: 1'b0, port: `SUP_DEF_PORT,
                       last: 32'h0000_0000, first: 32'h0000_0000};
      end
    end else if (wr_pend_q) begin
      if (wr_addr_q == `SUP_OFF_CTRL) begin
        d1_en_q <= HWDATA[`SUP_CTRL_D1_EN];
        d2_en_q <= HWDATA[`SUP_CTRL_D2_EN];
        proc_q  <= sup_pkg::sup_proc_t'(
                     HWDATA[`SUP_CTRL_PROC_HI:`SUP_CTRL_PROC_LO]);
      end else if (wr_addr_q == `SUP_OFF_DELIM) begin
        d1_q <= HWDATA[7:0];
        d2_q <= HWDATA[15:8];
      end else if (wr_addr_q == `SUP_OFF_PKTLEN) begin
        pktlen_q <= HWDATA[FW-1:0];
      end else if (wr_addr_q == `SUP_OFF_GAP) begin
        gap_q <= HWDATA[15:0];
      end else if (wr_addr_q == `SUP_OFF_LPORT) begin
        lport_q <= HWDATA[15:0];
      end else begin
        for (int i = 0; i < NUM_RANGES; i++) begin
          if (dest_hit(wr_addr_q, i, `SUP_DOFF_FIRST)) begin
            dest_q[i].first <= HWDATA;
          end else if (dest_hit(wr_addr_q, i, `SUP_DOFF_LAST)) begin
            dest_q[i].last <= HWDATA;
          end else if (dest_hit(wr_addr_q, i, `SUP_DOFF_PORT)) begin
            dest_q[i].port <= HWDATA[15:0];
            dest_q[i].en   <= HWDATA[`SUP_PORT_EN];   // R17
          end
        end
      end
    end
  end

  // ==========================================================
  // Flush decision
  logic          accept;
  logic          delim_on;
  logic          delim_done;
  logic          strip;
  logic          store;
  logic [FW-1:0] fill_d;
  logic          len_hit;
  logic          full_hit;
  logic          gap_hit;
  logic          post_hit;
  logic          delim_send;
  logic          flush;
  logic          start;

  always_comb begin
    accept   = RX_VALID && RX_READY;
    delim_on = (pktlen_q == '0) && d1_en_q;               // R05 R08
    delim_done = accept && delim_on && (post_q == 2'd0) &&
                 (d2_en_q ? (prev_d1_q && RX_DATA == d2_q) // R04
                          : (RX_DATA == d1_q));            // R03
    strip    = delim_done && proc_q == sup_pkg::PROC_STRIP; // R11
    store    = accept && !strip;
    fill_d   = fill_q;
    if (store) begin
      fill_d = fill_q + FW'(1);
    end else if (strip && d2_en_q && fill_q != '0) begin
      fill_d = fill_q - FW'(1);                      // R11
    end
    len_hit  = accept && pktlen_q != '0 && fill_d >= pktlen_q; // R01 R02
    full_hit = fill_d == FW'(BUF_BYTES);                  // R07 R14
    gap_hit  = !accept && gap_q != 16'h0000 && fill_q != '0 &&
               gap_cnt_q > {1'b0, gap_q};                 // R12 R13
    post_hit = accept && post_q == 2'd1;                  // R10
    delim_send = delim_done && (proc_q == sup_pkg::PROC_NONE ||
                                proc_q == sup_pkg::PROC_STRIP); // R09
    flush    = len_hit || full_hit || gap_hit || post_hit ||
               delim_send;                                // R23
    start    = flush && fill_d != '0;
  end

  // ==========================================================
  // Receive buffer and delimiter tracking
  always_ff @(posedge SYS_CLK) begin
    if (store) begin
      mem[fill_q[$clog2(BUF_BYTES)-1:0]] <= RX_DATA;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      fill_q     <= '0;
      prev_d1_q  <= 1'b0;
      post_q     <= 2'd0;
      send_len_q <= '0;
      flushes_q  <= 32'h0000_0000;
    end else if (flush) begin
      fill_q    <= '0;                                    // R23
      prev_d1_q <= 1'b0;
      post_q    <= 2'd0;
      if (start) begin
        send_len_q <= fill_d;
        flushes_q  <= flushes_q + 32'h0000_0001;
      end
    end else begin
      fill_q <= fill_d;
      if (accept) begin
        prev_d1_q <= RX_DATA == d1_q && !delim_done;
      end
      if (delim_done && proc_q == sup_pkg::PROC_PLUS1) begin
        post_q <= 2'd1;                                   // R10
      end else if (delim_done && proc_q == sup_pkg::PROC_PLUS2) begin
        post_q <= 2'd2;                                   // R10
      end else if (accept && post_q != 2'd0) begin
        post_q <= post_q - 2'd1;
      end
    end
  end

  // ==========================================================
  // Millisecond base and gap timer
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      ms_div_q  <= 32'h0000_0000;
      ms_tick_q <= 1'b0;
    end else begin
      ms_tick_q <= ms_div_q == 32'(MS_CYCLES - 1);
      ms_div_q  <= (ms_div_q == 32'(MS_CYCLES - 1)) ? 32'h0000_0000
                                                    : ms_div_q + 32'h1;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST || accept || flush) begin
      gap_cnt_q <= 17'h0_0000;                            // R22
    end else if (ms_tick_q && fill_q != '0 && !gap_cnt_q[16]) begin
      gap_cnt_q <= gap_cnt_q + 17'h0_0001;                // R22
    end
  end

  // ==========================================================
  // Datagram sender: each address of every enabled range, at most 64 per range; a broadcast range gets one datagram, to its first address
  logic [31:0] cur_ip;
  logic        bcast;
  logic        range_end;

  always_comb begin
    cur_ip    = '0;
    bcast     = 1'b0;
    range_end = 1'b1;
    if (range_q < 3'(NUM_RANGES)) begin
      cur_ip = dest_q[range_q[1:0]].first + {26'h000_0000, off_q};
      bcast  = dest_q[range_q[1:0]].first[7:0] == `SUP_BCAST_OCTET; // R19
      range_end = bcast || cur_ip == dest_q[range_q[1:0]].last ||
                  off_q == 6'(`SUP_RANGE_MAX - 1);        // R18
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      state_q  <= sup_pkg::ST_IDLE;
      RX_READY <= 1'b1;
      TX_VALID <= 1'b0;
      TX_DATA  <= 8'h00;
      TX_LAST  <= 1'b0;
      TX_HDR   <= '0;
      rd_q     <= '0;
      range_q  <= 3'd0;
      off_q    <= 6'd0;
    end else begin
      case (state_q)
        sup_pkg::ST_IDLE: begin
          if (start) begin
            RX_READY <= 1'b0;
            range_q  <= 3'd0;
            off_q    <= 6'd0;
            state_q  <= sup_pkg::ST_PICK;
          end
        end
        sup_pkg::ST_PICK: begin
          if (range_q >= 3'(NUM_RANGES)) begin
            RX_READY <= 1'b1;
            state_q  <= sup_pkg::ST_IDLE;
          end else if (!dest_q[range_q[1:0]].en) begin
            range_q <= range_q + 3'd1;                    // R17
          end else begin
            TX_HDR  <= '{dst_ip: cur_ip,
                         dst_port: dest_q[range_q[1:0]].port,
                         src_port: lport_q, len: send_len_q};
            rd_q    <= '0;
            state_q <= sup_pkg::ST_DATA;
          end
        end
        sup_pkg::ST_DATA: begin
          if (!TX_VALID || TX_READY) begin
            if (rd_q != send_len_q) begin
              TX_VALID <= 1'b1;
              TX_DATA  <= mem[rd_q[$clog2(BUF_BYTES)-1:0]];
              TX_LAST  <= rd_q == send_len_q - FW'(1);
              rd_q     <= rd_q + FW'(1);
            end else begin
              TX_VALID <= 1'b0;
              TX_LAST  <= 1'b0;
              state_q  <= sup_pkg::ST_NEXT;
            end
          end
        end
        sup_pkg::ST_NEXT: begin
          if (range_end) begin
            range_q <= range_q + 3'd1;
            off_q   <= 6'd0;
          end else begin
            off_q <= off_q + 6'd1;                        // R18
          end
          state_q <= sup_pkg::ST_PICK;
        end
        default: begin
          state_q <= sup_pkg::ST_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

/* verification/sup_net_sink.sv */
`timescale 1ns/1ps
`default_nettype none
module sup_net_sink (
  // Clock, reset, pacing
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                slow,
  // Datagram stream
  input  wire logic                tx_valid,
  input  wire logic [7:0]          tx_data,
  input  wire logic                tx_last,
  input  wire sup_pkg::sup_txhdr_t tx_hdr,
  output logic                     tx_ready
);
  logic [7:0]          data_q[$];
  sup_pkg::sup_txhdr_t hdr_q[$];
  logic                phase_q;
  // ==========================================================
  // Stall every other cycle when slow
  always_ff @(posedge clk) begin
    if (rst) begin
      phase_q <= 1'b0;
    end else begin
      phase_q <= ~phase_q;
    end
  end
  assign tx_ready = !rst && (!slow || phase_q);
  // ==========================================================
  // Collect bytes, close a datagram on its last byte
  always @(posedge clk) begin
    if (!rst && tx_valid && tx_ready) begin
      data_q.push_back(tx_data);
      if (tx_last) begin
        hdr_q.push_back(tx_hdr);
      end
    end
  end
endmodule
`default_nettype wire

/* verification/sup_packer_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module sup_packer_asserts #(
  parameter int BUF_BYTES = 1024
) (
  // Clock and reset
  input  wire logic                SYS_CLK,
  input  wire logic                SYS_RST,
  // Bus and streams
  input  wire logic                HREADYOUT,
  input  wire logic                HRESP,
  input  wire logic                RX_READY,
  input  wire logic                TX_VALID,
  input  wire logic [7:0]          TX_DATA,
  input  wire logic                TX_LAST,
  input  wire sup_pkg::sup_txhdr_t TX_HDR,
  input  wire logic                TX_READY
);
  logic [10:0] beat_q;
  // ==========================================================
  // Byte position inside the current datagram
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      beat_q <= 11'h000;
    end else if (TX_VALID && TX_READY) begin
      beat_q <= TX_LAST ? 11'h000 : beat_q + 11'h001;
    end
  end
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (SYS_RST);
  // ==========================================================
  // Assertions
  AST_RESET_IDLE: assert property ($fell(SYS_RST) |->
    !TX_VALID && RX_READY && HREADYOUT) else $error("bad state after reset");
  AST_BUS_OKAY: assert property (HREADYOUT && !HRESP)
    else $error("bus not ready or error response");
  AST_TX_HOLD: assert property (TX_VALID && !TX_READY |=> TX_VALID &&
    $stable(TX_DATA) && $stable(TX_LAST)) else $error("byte dropped");
  AST_HDR_STABLE: assert property (TX_VALID && $past(TX_VALID) |->
    $stable(TX_HDR)) else $error("header changed in datagram");
  AST_LAST_POS: assert property (TX_VALID && TX_LAST |->
    beat_q == TX_HDR.len - 11'h001) else $error("last flag misplaced");
  AST_LEN_RANGE: assert property (TX_VALID |-> TX_HDR.len != 11'h000 &&
    int'(TX_HDR.len) <= BUF_BYTES) else $error("length out of range");
  AST_LAST_GAP: assert property (TX_VALID && TX_READY && TX_LAST |=>
    !TX_VALID [*2]) else $error("no gap between datagrams");
  AST_NO_RX_IN_TX: assert property (TX_VALID |-> !RX_READY)
    else $error("input taken while sending");
  AST_STALL_FIRST: assert property ($rose(TX_VALID) |->
    !$past(RX_READY)) else $error("send without prior stall");
  // ==========================================================
  // Covers
  COV_LAST: cover property (TX_VALID && TX_READY && TX_LAST);
  COV_STALL: cover property (TX_VALID && !TX_READY);
  COV_RX_HELD: cover property (!RX_READY && !TX_VALID);
endmodule
bind sup_packer sup_packer_asserts #(.BUF_BYTES(BUF_BYTES))
  u_sup_packer_asserts (
  .SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .HREADYOUT(HREADYOUT),
  .HRESP(HRESP), .RX_READY(RX_READY), .TX_VALID(TX_VALID),
  .TX_DATA(TX_DATA), .TX_LAST(TX_LAST), .TX_HDR(TX_HDR),
  .TX_READY(TX_READY));
`default_nettype wire

/* verification/sup_packer_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sup_map.svh"
module sup_packer_bench;
  logic                SYS_CLK, SYS_RST, HSEL, HWRITE, HREADYOUT, HRESP;
  logic [11:0]         HADDR;
  logic [1:0]          HTRANS;
  logic [31:0]         HWDATA, HRDATA;
  logic                RX_VALID, RX_READY, TX_VALID, TX_LAST, TX_READY;
  logic [7:0]          RX_DATA, TX_DATA;
  sup_pkg::sup_txhdr_t TX_HDR;
  logic                slow;
  int                  miscompares, comparisons, cycles;
  logic [10:0]         proc_len [4] = '{11'h002, 11'h003, 11'h004, 11'h001};
  logic [7:0]          proc_end [4] = '{8'h0d, 8'h55, 8'h55, 8'h41};
  sup_packer #(.BUF_BYTES(8), .MS_CYCLES(4)) u_sup_packer (
    .SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA),
    .HREADY(HREADYOUT), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .HRDATA(HRDATA), .RX_VALID(RX_VALID), .RX_DATA(RX_DATA),
    .RX_READY(RX_READY), .TX_VALID(TX_VALID), .TX_DATA(TX_DATA),
    .TX_LAST(TX_LAST), .TX_HDR(TX_HDR), .TX_READY(TX_READY));
  sup_net_sink u_sup_net_sink (
    .clk(SYS_CLK), .rst(SYS_RST), .slow(slow), .tx_valid(TX_VALID),
    .tx_data(TX_DATA), .tx_last(TX_LAST), .tx_hdr(TX_HDR),
    .tx_ready(TX_READY));
  always #12.5 SYS_CLK = ~SYS_CLK;
  // ==========================================================
  // Tasks
  task automatic stop_test();
    if (miscompares == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    HSEL <= 1'b1;
    HTRANS <= 2'b10;
    HADDR <= a;
    HWRITE <= w;
    do @(posedge SYS_CLK); while (HREADYOUT !== 1'b1);
    HSEL <= 1'b0;
    HTRANS <= 2'b00;
    HWDATA <= d;
    do @(posedge SYS_CLK); while (HREADYOUT !== 1'b1);
    r = HRDATA;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask
  task automatic rd(input string n, input logic [11:0] a,
                    input logic [31:0] e);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    chk(n, e, r);
  endtask
  task automatic send(input logic [7:0] b);
    RX_VALID <= 1'b1;
    RX_DATA <= b;
    do @(posedge SYS_CLK); while (RX_READY !== 1'b1);
  endtask
  // Release the line, data shows garbage while idle
  task automatic idle(input int n);
    RX_VALID <= 1'b0;
    RX_DATA <= ~RX_DATA;
    repeat (n) @(posedge SYS_CLK);
  endtask
  task automatic wait_dg(input int n);
    int t;
    t = 0;
    while (u_sup_net_sink.hdr_q.size() < n && t < 400) begin
      @(posedge SYS_CLK);
      t++;
    end
    repeat (n == 0 ? 40 : 10) @(posedge SYS_CLK);
  endtask
  task automatic expect_dg(input int n, input logic [10:0] l,
                           input logic [7:0] b);
    wait_dg(n);
    chk("count", 32'(n), 32'(u_sup_net_sink.hdr_q.size()));
    if (n > 0) begin
      chk("len", {21'h0, l}, {21'h0, u_sup_net_sink.hdr_q[0].len});
      chk("last byte", {24'h0, b}, {24'h0, u_sup_net_sink.data_q[l-1]});
    end
    u_sup_net_sink.hdr_q.delete();
    u_sup_net_sink.data_q.delete();
  endtask
  // ==========================================================
  // Timeout
  always @(posedge SYS_CLK) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      stop_test();
    end
  end
  // ==========================================================
  // Tests
  initial begin
    SYS_CLK = 1'b0;
    SYS_RST = 1'b1;
    {HSEL, HWRITE, HADDR, HTRANS, HWDATA} = '0;
    {RX_VALID, RX_DATA, slow} = '0;
    {miscompares, comparisons, cycles} = '0;
    repeat (20) @(posedge SYS_CLK);
    SYS_RST <= 1'b0;
    @(posedge SYS_CLK);
    rd("ctrl", `SUP_OFF_CTRL, 32'h0);
    rd("delim", `SUP_OFF_DELIM, 32'h0);
    rd("pktlen", `SUP_OFF_PKTLEN, 32'h0);
    rd("gap", `SUP_OFF_GAP, 32'h0);
    rd("lport", `SUP_OFF_LPORT, 32'h00000fa1);
    rd("dport", `SUP_OFF_DEST0 + `SUP_DOFF_PORT, 32'h00000fa1);
    rd("unmapped", 12'hffc, 32'h0);
    wr(`SUP_OFF_DEST0, 32'h0a000001);
    wr(`SUP_OFF_DEST0 + `SUP_DOFF_LAST, 32'h0a000002);
    wr(`SUP_OFF_DEST0 + `SUP_DOFF_PORT, 32'h00011234);
    wr(`SUP_OFF_PKTLEN, 32'h3);
    slow <= 1'b1;
    send(8'h10);
    send(8'h11);
    send(8'h12);
    idle(1);
    wait_dg(2);
    chk("ip0", 32'h0a000001, u_sup_net_sink.hdr_q[0].dst_ip);
    chk("ip1", 32'h0a000002, u_sup_net_sink.hdr_q[1].dst_ip);
    chk("dport", 32'h1234, {16'h0, u_sup_net_sink.hdr_q[0].dst_port});
    chk("sport", 32'h0fa1, {16'h0, u_sup_net_sink.hdr_q[0].src_port});
    expect_dg(2, 11'h003, 8'h12);
    wr(`SUP_OFF_DEST0 + `SUP_DOFF_LAST, 32'h0a000001);
    wr(`SUP_OFF_DELIM, 32'h0000000d);
    wr(`SUP_OFF_CTRL, 32'h1);
    wr(`SUP_OFF_PKTLEN, 32'h4);
    repeat (4) send(8'h0d);
    idle(1);
    expect_dg(1, 11'h004, 8'h0d);
    wr(`SUP_OFF_PKTLEN, 32'h0);
    slow <= 1'b0;
    for (int p = 0; p < 4; p++) begin
      wr(`SUP_OFF_CTRL, {28'h0, 2'(p), 2'b01});
      send(8'h41);
      send(8'h0d);
      repeat (p % 3) send(8'h55);
      idle(1);
      expect_dg(1, proc_len[p], proc_end[p]);
    end
    wr(`SUP_OFF_DELIM, 32'h00000a0d);
    wr(`SUP_OFF_CTRL, 32'h3);
    send(8'h41);
    send(8'h0d);
    send(8'h42);
    idle(1);
    expect_dg(0, 11'h000, 8'h00);
    send(8'h0d);
    send(8'h0a);
    idle(1);
    expect_dg(1, 11'h005, 8'h0a);
    wr(`SUP_OFF_CTRL, 32'h4);
    send(8'h0d);
    send(8'h41);
    idle(1);
    expect_dg(0, 11'h000, 8'h00);
    wr(`SUP_OFF_CTRL, 32'h1);
    for (int i = 0; i < 6; i++) send(8'h60 + 8'(i));
    idle(1);
    expect_dg(1, 11'h008, 8'h65);
    send(8'h41);
    idle(1);
    expect_dg(0, 11'h000, 8'h00);
    rd("status", `SUP_OFF_STATUS, 32'h1);
    wr(`SUP_OFF_GAP, 32'h2);
    expect_dg(1, 11'h001, 8'h41);
    send(8'h42);
    idle(6);
    chk("early gap", 32'h0, 32'(u_sup_net_sink.hdr_q.size()));
    expect_dg(1, 11'h001, 8'h42);
    wr(`SUP_OFF_DEST0, 32'h0a0000ff);
    wr(`SUP_OFF_DEST0 + `SUP_DOFF_LAST, 32'h0a000010);
    send(8'h43);
    idle(1);
    wait_dg(1);
    chk("bcast ip", 32'h0a0000ff, u_sup_net_sink.hdr_q[0].dst_ip);
    expect_dg(1, 11'h001, 8'h43);
    wr(`SUP_OFF_DEST0 + `SUP_DOFF_PORT, 32'h00001234);
    send(8'h44);
    idle(1);
    expect_dg(0, 11'h000, 8'h00);
    rd("flushes", `SUP_OFF_FLUSHES, 32'h0000000c);
    stop_test();
  end
endmodule
`default_nettype wire
